// ---- include/evt_timer_pkg.sv ----
// Shared constants and types for the eight-bit timer and event counter
package evt_timer_pkg;

    // Register byte offsets on the AXI4-Lite bus
    localparam logic [3:0] OFS_CONTROL    = 4'h0;
    localparam logic [3:0] OFS_COUNT      = 4'h4;
    localparam logic [3:0] OFS_IRQ_CONFIG = 4'h8;

    // Control register reset value (edge select high, all else clear)
    localparam logic [7:0] CONTROL_RESET  = 8'h08;
    // Interrupt enable reset value
    localparam logic       IRQ_EN_RESET   = 1'b0;
    // Counter reset value and full-count value
    localparam logic [7:0] COUNT_RESET    = 8'h00;
    localparam logic [7:0] COUNT_FULL     = 8'hFF;
    localparam logic [7:0] COUNT_ONE      = 8'h01;

    // AXI response codes
    localparam logic [1:0] RESP_OKAY      = 2'b00;
    localparam logic [1:0] RESP_SLVERR    = 2'b10;

    // Operating modes held in the two top control bits
    localparam logic [1:0] MODE_NONE      = 2'b00;
    localparam logic [1:0] MODE_EVENT     = 2'b01;
    localparam logic [1:0] MODE_TIMER     = 2'b10;
    localparam logic [1:0] MODE_CAPTURE   = 2'b11;

    // Control register layout, bit 7 down to bit 0
    typedef struct packed {
        logic [1:0] mode_select;          // Mode pair, hi then lo
        logic       clock_source_select;  // 0 system clock, 1 crystal
        logic       run_enable_bit;       // Counting gate
        logic       edge_polarity_select; // Active edge choice
        logic [2:0] prescale_select;      // Divide by two to the code
    } counter_control_t;

    // Pulse capture sequencing
    typedef enum logic [0:0] {
        CAP_ARMED,
        CAP_COUNTING
    } capture_state_t;

endpackage

// ---- hdl/edge_sync.sv ----
// Three-stage synchroniser with agreement filter and edge pulses
`timescale 1ns/10ps
module edge_sync (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic nrst_i,
    // Asynchronous input
    input  wire logic async_i,
    // Filtered level and one-cycle edge pulses
    output logic      level_o,
    output logic      rise_o,
    output logic      fall_o
);

    logic s1_r;      // First stage, read only by second
    logic s2_r;      // Second stage
    logic s3_r;      // Third stage
    logic stable_r;  // Level accepted after agreement
    logic agree;     // Second and third stages match

    assign agree   = (s2_r == s3_r);
    assign rise_o  = agree & s3_r & ~stable_r;
    assign fall_o  = agree & ~s3_r & stable_r;
    assign level_o = stable_r;

    // Shift chain; a change counts once stages two and three agree
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            // Chain keeps following the pin, so release shows no false edge
            // Limitation: reset must last four cycles for the chain to settle
            s1_r     <= async_i;
            s2_r     <= s1_r;
            s3_r     <= s2_r;
            stable_r <= s3_r;
        end else begin
            s1_r     <= async_i;
            s2_r     <= s1_r;
            s3_r     <= s2_r;
            stable_r <= agree ? s3_r : stable_r;
        end
    end

endmodule

// ---- hdl/clock_prescaler.sv ----
// Power-of-two prescaler producing one tick per divided falling edge
`timescale 1ns/10ps
module clock_prescaler #(
    parameter int PSC_W = 7
) (
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       nrst_i,
    // Source clock ticks and divide code
    input  wire logic       src_tick_i,
    input  wire logic [2:0] psc_sel_i,
    // One-cycle tick of the divided clock
    output logic            tick_o
);

    logic [PSC_W-1:0] div_r;  // Free-running divide chain
    logic [PSC_W-1:0] mask;   // Low bits that must be all ones
    logic [PSC_W:0]   one_hot; // Two to the code

    // Divided clock falls when its bit and all below are ones
    assign one_hot = (PSC_W+1)'(1) << psc_sel_i;
    assign mask    = PSC_W'(one_hot - (PSC_W+1)'(1));
    assign tick_o  = src_tick_i & ((div_r & mask) == mask);

    // Chain advances on every source tick, whatever the mode
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            div_r <= '0;
        end else if (src_tick_i) begin
            div_r <= div_r + PSC_W'(1);
        end
    end

endmodule

// ---- hdl/eight_bit_timer_event_counter.sv ----
// Eight-bit timer, event counter and pulse width capture with AXI4-Lite registers
`timescale 1ns/10ps
module eight_bit_timer_event_counter
    import evt_timer_pkg::*;
#(
    parameter int ADDR_W = 4,
    parameter int PSC_W  = 7
) (
    // Clock and reset
    input  wire logic              clk_i,
    input  wire logic              nrst_i,
    // AXI4-Lite write address
    input  wire logic [ADDR_W-1:0] s_axi_awaddr_i,
    input  wire logic              s_axi_awvalid_i,
    output logic                   s_axi_awready_o,
    // AXI4-Lite write data
    input  wire logic [31:0]       s_axi_wdata_i,
    input  wire logic [3:0]        s_axi_wstrb_i,
    input  wire logic              s_axi_wvalid_i,
    output logic                   s_axi_wready_o,
    // AXI4-Lite write response
    output logic [1:0]             s_axi_bresp_o,
    output logic                   s_axi_bvalid_o,
    input  wire logic              s_axi_bready_i,
    // AXI4-Lite read address
    input  wire logic [ADDR_W-1:0] s_axi_araddr_i,
    input  wire logic              s_axi_arvalid_i,
    output logic                   s_axi_arready_o,
    // AXI4-Lite read data
    output logic [31:0]            s_axi_rdata_o,
    output logic [1:0]             s_axi_rresp_o,
    output logic                   s_axi_rvalid_o,
    input  wire logic              s_axi_rready_i,
    // External pins and neighbouring units
    input  wire logic              external_count_pin_i,
    input  wire logic              low_speed_crystal_i,
    input  wire logic              pwm_active_i,
    // Events and shared clock
    output logic                   irq_o,
    output logic                   wake_o,
    output logic                   prescaler_input_tick_o
);

    // Bus write channel state
    logic              aw_held_r;   // Write address captured
    logic [ADDR_W-1:0] awaddr_r;    // Captured write address
    logic              w_held_r;    // Write data captured
    logic [31:0]       wdata_r;     // Captured write data
    logic              wstrb0_r;    // Low byte lane enabled
    logic              bvalid_r;    // Write response pending
    logic [1:0]        bresp_r;     // Write response code
    // Bus read channel state
    logic              rvalid_r;    // Read data pending
    logic [31:0]       rdata_r;     // Read data word
    logic [1:0]        rresp_r;     // Read response code

    // Register state
    counter_control_t  ctrl_r;      // Control register
    counter_control_t  ctrl_nxt;
    logic              irq_en_r;    // Overflow interrupt enable
    logic [7:0]        preload_r;   // Preload, left uninitialised
    logic [7:0]        count_r;     // Live counter
    logic [7:0]        count_nxt;
    capture_state_t    cap_r;       // Capture sequencer
    capture_state_t    cap_nxt;

    // Decoded bus events
    logic do_wr;        // Both write halves present, response free
    logic wr_ctrl;      // Control register write
    logic wr_count;     // Preload write
    logic wr_irq;       // Interrupt config write
    logic wr_hit;       // Write address mapped
    logic ar_take;      // Read address handshake
    logic rd_hit;       // Read address mapped
    logic [31:0] rd_word; // Decoded read value

    // Pin and clock conditioning
    logic pin_rise;     // Count pin rising edge
    logic pin_fall;     // Count pin falling edge
    logic lxt_rise;     // Crystal clock rising edge
    logic src_tick;     // Selected prescaler input tick
    logic psc_tick;     // Prescaled clock falling edge

    // Counting decisions
    logic mode_event;   // Event counting selected
    logic mode_timer;   // Interval timer selected
    logic mode_cap;     // Pulse capture selected
    logic evt_edge;     // Qualifying event edge
    logic cap_start;    // Capture start edge
    logic cap_stop;     // Capture stop edge
    logic cap_end;      // Capture finishes this cycle
    logic inc;          // Counter advances this cycle
    logic ovf;          // Counter overflows this cycle

    // Count pin passes three stages before edge detection
    edge_sync u_pin_sync (
        .clk_i   (clk_i),
        .nrst_i  (nrst_i),
        .async_i (external_count_pin_i),
        .level_o (),
        .rise_o  (pin_rise),
        .fall_o  (pin_fall)
    );

    // Crystal is far slower than the system clock, so it is sampled
    edge_sync u_lxt_sync (
        .clk_i   (clk_i),
        .nrst_i  (nrst_i),
        .async_i (low_speed_crystal_i),
        .level_o (),
        .rise_o  (lxt_rise),
        .fall_o  ()
    );

    // Prescaler input: pulse modulation overrides the source bit
    assign src_tick = (pwm_active_i || !ctrl_r.clock_source_select) ? 1'b1 : lxt_rise;
    assign prescaler_input_tick_o = src_tick;

    // Divider on the selected internal clock
    clock_prescaler #(
        .PSC_W (PSC_W)
    ) u_prescaler (
        .clk_i      (clk_i),
        .nrst_i     (nrst_i),
        .src_tick_i (src_tick),
        .psc_sel_i  (ctrl_r.prescale_select),
        .tick_o     (psc_tick)
    );

    // Mode decode
    assign mode_event = (ctrl_r.mode_select == MODE_EVENT);
    assign mode_timer = (ctrl_r.mode_select == MODE_TIMER);
    assign mode_cap   = (ctrl_r.mode_select == MODE_CAPTURE);

    // Event edges bypass the prescaler entirely
    assign evt_edge  = ctrl_r.edge_polarity_select ? pin_fall : pin_rise;
    // Capture polarity: zero waits for a low pulse, one for a high pulse
    assign cap_start = ctrl_r.edge_polarity_select ? pin_rise : pin_fall;
    assign cap_stop  = ctrl_r.edge_polarity_select ? pin_fall : pin_rise;
    assign cap_end   = mode_cap && ctrl_r.run_enable_bit && (cap_r == CAP_COUNTING) && cap_stop;

    // Counting source by mode; no mode means no counting
    assign inc = ctrl_r.run_enable_bit &&
                 ((mode_event && evt_edge) ||
                  (mode_timer && psc_tick) ||
                  (mode_cap && (cap_r == CAP_COUNTING) && !cap_stop && psc_tick));
    assign ovf = inc && (count_r == COUNT_FULL);

    // Overflow pulse; sleep does not stop this logic
    assign wake_o = ovf;
    assign irq_o  = ovf && irq_en_r;

    // Write decode from the captured address
    assign do_wr    = aw_held_r && w_held_r && !bvalid_r;
    assign wr_ctrl  = do_wr && wstrb0_r && (awaddr_r == OFS_CONTROL);
    assign wr_count = do_wr && wstrb0_r && (awaddr_r == OFS_COUNT);
    assign wr_irq   = do_wr && wstrb0_r && (awaddr_r == OFS_IRQ_CONFIG);
    assign wr_hit   = (awaddr_r == OFS_CONTROL) || (awaddr_r == OFS_COUNT) ||
                      (awaddr_r == OFS_IRQ_CONFIG);

    // Read decode; count reads return the live counter
    assign ar_take = s_axi_arvalid_i && !rvalid_r;
    assign rd_hit  = (s_axi_araddr_i == OFS_CONTROL) || (s_axi_araddr_i == OFS_COUNT) ||
                     (s_axi_araddr_i == OFS_IRQ_CONFIG);
    assign rd_word = (s_axi_araddr_i == OFS_CONTROL)    ? {24'h00_0000, ctrl_r} :
                     (s_axi_araddr_i == OFS_COUNT)      ? {24'h00_0000, count_r} :
                     (s_axi_araddr_i == OFS_IRQ_CONFIG) ? {31'h0000_0000, irq_en_r} :
                                                          32'h0000_0000;

    // Handshake outputs
    assign s_axi_awready_o = !aw_held_r;
    assign s_axi_wready_o  = !w_held_r;
    assign s_axi_arready_o = !rvalid_r;
    assign s_axi_bvalid_o  = bvalid_r;
    assign s_axi_bresp_o   = bresp_r;
    assign s_axi_rvalid_o  = rvalid_r;
    assign s_axi_rdata_o   = rdata_r;
    assign s_axi_rresp_o   = rresp_r;

    // Control next value; a software write beats the capture auto-clear
    always_comb begin
        ctrl_nxt = ctrl_r;
        if (wr_ctrl) begin
            ctrl_nxt = counter_control_t'(wdata_r[7:0]);
        end else if (cap_end) begin
            ctrl_nxt.run_enable_bit = 1'b0;
        end
    end

    // Capture sequencer: enable only arms, the start edge runs it
    always_comb begin
        cap_nxt = cap_r;
        case (cap_r)
            CAP_ARMED: begin
                if (mode_cap && ctrl_r.run_enable_bit && cap_start) begin
                    cap_nxt = CAP_COUNTING;
                end
            end
            CAP_COUNTING: begin
                // Leaving capture or losing enable disarms the sequencer
                if (!mode_cap || !ctrl_r.run_enable_bit || cap_stop) begin
                    cap_nxt = CAP_ARMED;
                end
            end
            default: begin
                cap_nxt = CAP_ARMED;
            end
        endcase
    end

    // Counter next value
    always_comb begin
        count_nxt = count_r;
        if (wr_count && !ctrl_r.run_enable_bit) begin
            count_nxt = wdata_r[7:0];
        end else if (ovf) begin
            // Preload written this cycle takes effect at once
            count_nxt = wr_count ? wdata_r[7:0] : preload_r;
        end else if (inc) begin
            count_nxt = count_r + COUNT_ONE;
        end
    end

    // Preload has no reset: software must write it before use
    always_ff @(posedge clk_i) begin
        if (wr_count) begin
            preload_r <= wdata_r[7:0];
        end
    end

    // Timer state registers
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            ctrl_r   <= counter_control_t'(CONTROL_RESET);
            irq_en_r <= IRQ_EN_RESET;
            count_r  <= COUNT_RESET;
            cap_r    <= CAP_ARMED;
        end else begin
            ctrl_r   <= ctrl_nxt;
            irq_en_r <= wr_irq ? wdata_r[0] : irq_en_r;
            count_r  <= count_nxt;
            cap_r    <= cap_nxt;
        end
    end

    // Write address and data captured independently, in either order
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            aw_held_r <= 1'b0;
            awaddr_r  <= '0;
            w_held_r  <= 1'b0;
            wdata_r   <= 32'h0000_0000;
            wstrb0_r  <= 1'b0;
        end else begin
            if (s_axi_awvalid_i && !aw_held_r) begin
                aw_held_r <= 1'b1;
                awaddr_r  <= s_axi_awaddr_i;
            end else if (do_wr) begin
                aw_held_r <= 1'b0;
            end
            if (s_axi_wvalid_i && !w_held_r) begin
                w_held_r <= 1'b1;
                wdata_r  <= s_axi_wdata_i;
                wstrb0_r <= s_axi_wstrb_i[0];
            end else if (do_wr) begin
                w_held_r <= 1'b0;
            end
        end
    end

    // Write response; unmapped addresses answer with a slave error
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            bvalid_r <= 1'b0;
            bresp_r  <= RESP_OKAY;
        end else if (do_wr) begin
            bvalid_r <= 1'b1;
            bresp_r  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready_i) begin
            bvalid_r <= 1'b0;
        end
    end

    // Read response registered one cycle after the address
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            rvalid_r <= 1'b0;
            rdata_r  <= 32'h0000_0000;
            rresp_r  <= RESP_OKAY;
        end else if (ar_take) begin
            rvalid_r <= 1'b1;
            rdata_r  <= rd_word;
            rresp_r  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready_i) begin
            rvalid_r <= 1'b0;
        end
    end

    // Overflow only from a full counter; interrupt follows its enable
    chk_irq_gated: assert property (@(posedge clk_i) disable iff (!nrst_i)
        wake_o |-> (count_r == COUNT_FULL) && (irq_o == irq_en_r))
        else $error("overflow or interrupt gating wrong");

    // Overflow reloads the preload value on the next cycle
    chk_ovf_reload: assert property (@(posedge clk_i) disable iff (!nrst_i)
        ovf |=> (count_r == preload_r))
        else $error("overflow did not reload preload");

    // Stopped preload write lands in the counter
    chk_stop_copy: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (wr_count && !ctrl_r.run_enable_bit) |=> (count_r == $past(wdata_r[7:0])))
        else $error("stopped preload write not copied");

    // Running preload write leaves the counter alone
    chk_run_hold: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (wr_count && ctrl_r.run_enable_bit && !inc) |=> (count_r == $past(count_r)))
        else $error("running preload write disturbed counter");

    // Halted counter stays put without writes
    chk_halt_hold: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (!ctrl_r.run_enable_bit && !wr_count) |=> $stable(count_r))
        else $error("halted counter moved");

    // Event mode advances by one on the chosen edge
    chk_event_step: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (mode_event && ctrl_r.run_enable_bit && !wr_count && !wr_ctrl &&
         (count_r != COUNT_FULL) && (ctrl_r.edge_polarity_select ? pin_fall : pin_rise))
        |=> (count_r == $past(count_r) + COUNT_ONE))
        else $error("event edge did not advance counter");

    // Capture end clears enable and then the count freezes
    chk_cap_freeze: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (cap_end && !wr_ctrl && !wr_count) |=> !ctrl_r.run_enable_bit ##1 $stable(count_r))
        else $error("capture end did not freeze counter");

    // Pulse modulation forces the system clock ticks
    chk_pwm_source: assert property (@(posedge clk_i) disable iff (!nrst_i)
        pwm_active_i |-> prescaler_input_tick_o)
        else $error("pulse modulation did not force system clock");

    // Armed capture never counts before its start edge
    chk_cap_armed: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (mode_cap && (cap_r == CAP_ARMED) && !wr_count) |=> $stable(count_r))
        else $error("capture counted before start edge");

endmodule

// ---- sim/pulse_source.sv ----
// Model of the external event source on the count pin
`timescale 1ns/10ps
module pulse_source (
    // Clock
    input  wire logic clk_i,
    // Count pin, idles high as a pulled-up input would
    output logic      pin_o
);
    initial pin_o = 1'b1;

    // Low phase then high phase; both wider than the pin filter
    task automatic pulses(input int n, input int lo, input int hi);
        for (int i = 0; i < n; i++) begin
            @(posedge clk_i);
            pin_o <= 1'b0;
            repeat (lo) @(posedge clk_i);
            pin_o <= 1'b1;
            repeat (hi) @(posedge clk_i);
        end
    endtask
endmodule

// ---- sim/tb_top.sv ----
// Self-checking bench for the eight-bit timer and event counter
`timescale 1ns/10ps
module tb_top
    import evt_timer_pkg::*;
;
    // Stimulus, all valued at time zero
    logic clk_i = 1'b0, nrst_i = 1'b0, low_speed_crystal_i = 1'b0, pwm_active_i = 1'b0;
    logic [3:0] s_axi_awaddr_i = 4'h0, s_axi_araddr_i = 4'h0;
    logic s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_bready_i = 1'b0;
    logic s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b0;
    logic [31:0] s_axi_wdata_i = 32'h0000_0000, s_axi_rdata_o, rd_data;
    logic [1:0] s_axi_bresp_o, s_axi_rresp_o, resp;
    logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
    logic irq_o, wake_o, prescaler_input_tick_o, pin;
    int failures = 0, n_tests = 0;

    always #2 clk_i = ~clk_i;

    pulse_source src (.clk_i, .pin_o(pin));
    eight_bit_timer_event_counter DUT (.clk_i, .nrst_i, .s_axi_awaddr_i, .s_axi_awvalid_i,
        .s_axi_awready_o, .s_axi_wdata_i, .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i,
        .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i,
        .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o,
        .s_axi_rready_i, .external_count_pin_i(pin), .low_speed_crystal_i, .pwm_active_i,
        .irq_o, .wake_o, .prescaler_input_tick_o);

    // Verdict and end of run
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // Exact comparison, four-state safe
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            failures++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Window comparison for counts with synchroniser slack
    task automatic chk_rng(input string nm, input int lo, input int hi, input logic [31:0] g);
        n_tests++;
        if ((g >= lo && g <= hi) !== 1'b1) begin
            failures++;
            $display("wrong value %s expected %0d..%0d seen %h", nm, lo, hi, g);
        end
    endtask

    // Bus write; ready sampled mid-cycle equals its value at the next edge
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        logic aw_go, w_go, b_go;
        @(posedge clk_i);
        s_axi_awaddr_i <= a;
        s_axi_wdata_i <= {24'h00_0000, d};
        s_axi_awvalid_i <= 1'b1;
        s_axi_wvalid_i <= 1'b1;
        s_axi_bready_i <= 1'b1;
        for (int n = 0; n < 60; n++) begin
            @(negedge clk_i);
            aw_go = s_axi_awvalid_i && s_axi_awready_o;
            w_go = s_axi_wvalid_i && s_axi_wready_o;
            b_go = s_axi_bvalid_o;
            resp = s_axi_bresp_o;
            @(posedge clk_i);
            if (aw_go) s_axi_awvalid_i <= 1'b0;
            if (w_go) s_axi_wvalid_i <= 1'b0;
            if (b_go) begin
                s_axi_bready_i <= 1'b0;
                return;
            end
        end
        failures++;
        report_and_stop();
    endtask

    // Bus read into rd_data and resp
    task automatic rd(input logic [3:0] a);
        logic ar_go, r_go;
        @(posedge clk_i);
        s_axi_araddr_i <= a;
        s_axi_arvalid_i <= 1'b1;
        s_axi_rready_i <= 1'b1;
        for (int n = 0; n < 60; n++) begin
            @(negedge clk_i);
            ar_go = s_axi_arvalid_i && s_axi_arready_o;
            r_go = s_axi_rvalid_o;
            rd_data = s_axi_rdata_o;
            resp = s_axi_rresp_o;
            @(posedge clk_i);
            if (ar_go) s_axi_arvalid_i <= 1'b0;
            if (r_go) begin
                s_axi_rready_i <= 1'b0;
                return;
            end
        end
        failures++;
        report_and_stop();
    endtask

    // Reset values, unmapped place, preload while stopped and running
    task automatic reg_case();
        rd(OFS_CONTROL);
        chk("control", 32'h0000_0008, rd_data);
        rd(OFS_IRQ_CONFIG);
        chk("irq enable", 32'h0000_0000, rd_data);
        rd(4'hC);
        chk("unmapped read", RESP_SLVERR, resp);
        wr(4'hC, 8'h55);
        chk("unmapped write", RESP_SLVERR, resp);
        wr(OFS_COUNT, 8'h33);
        rd(OFS_COUNT);
        chk("stopped preload", 32'h0000_0033, rd_data);
        wr(OFS_CONTROL, 8'h10);
        wr(OFS_COUNT, 8'h77);
        rd(OFS_COUNT);
        chk("running preload", 32'h0000_0033, rd_data);
    endtask

    // Interval timer: overflow spacing per prescale code, irq gating
    task automatic timer_case(input logic [2:0] c, input logic en);
        int gap = 0;
        int irqs = 0;
        wr(OFS_CONTROL, 8'h00);
        wr(OFS_IRQ_CONFIG, {7'h00, en});
        wr(OFS_COUNT, 8'hFC);
        wr(OFS_CONTROL, {MODE_TIMER, 3'b010, c});
        do @(negedge clk_i); while (wake_o !== 1'b1 && ++gap < 1200);
        chk("first overflow", 1, gap < 1200);
        gap = 0;
        do begin
            @(negedge clk_i);
            gap++;
            irqs += irq_o;
        end while (wake_o !== 1'b1 && gap < 600);
        chk("timer period", 4 << c, gap);
        chk("irq pulses", en, irqs);
    endtask

    // Event counting on either edge, prescaler set to its slowest
    task automatic event_case(input logic eg, input int n);
        wr(OFS_CONTROL, {MODE_EVENT, 2'b00, eg, 3'b111});
        wr(OFS_COUNT, 8'h00);
        wr(OFS_CONTROL, {MODE_EVENT, 2'b01, eg, 3'b111});
        src.pulses(n, 6, 6);
        repeat (8) @(posedge clk_i);
        rd(OFS_COUNT);
        chk("event count", n, rd_data);
    endtask

    // Single-shot pulse width capture starting on a falling edge
    task automatic capture_case();
        wr(OFS_CONTROL, 8'hC0);
        wr(OFS_COUNT, 8'h00);
        wr(OFS_CONTROL, 8'hD0);
        repeat (20) @(posedge clk_i);
        rd(OFS_COUNT);
        chk("armed count", 32'h0000_0000, rd_data);
        src.pulses(1, 40, 10);
        rd(OFS_CONTROL);
        chk("auto stop", 32'h0000_00C0, rd_data);
        rd(OFS_COUNT);
        chk_rng("pulse width", 38, 42, rd_data);
        src.pulses(1, 30, 10);
        rd(OFS_COUNT);
        chk_rng("frozen width", 38, 42, rd_data);
    endtask

    // Shared prescaler input: ticks seen over 20 cycles
    task automatic tick_case(input logic pw, input logic x, input int e);
        int t = 0;
        @(posedge clk_i);
        pwm_active_i <= pw;
        low_speed_crystal_i <= x;
        repeat (20) begin
            @(negedge clk_i);
            t += prescaler_input_tick_o;
        end
        chk("input ticks", e, t);
    endtask

    // Main sequence
    initial begin
        repeat (20) @(posedge clk_i);
        nrst_i <= 1'b1;
        reg_case();
        for (int c = 0; c < 8; c++) timer_case(c[2:0], c[0]);
        event_case(1'b0, 5);
        event_case(1'b1, 3);
        capture_case();
        wr(OFS_CONTROL, 8'h20);
        tick_case(1'b0, 1'b0, 0);
        tick_case(1'b0, 1'b1, 1);
        tick_case(1'b1, 1'b1, 20);
        wr(OFS_CONTROL, 8'h00);
        tick_case(1'b0, 1'b0, 20);
        report_and_stop();
    end
endmodule
